// file: itmr_cfg.svh
// Purpose: offsets, field positions and reset values of the interval timer
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: definitions only
`ifndef ITMR_CFG_SVH
`define ITMR_CFG_SVH

// register map, one aligned word each
`define ITMR_CH_STRIDE 8'h10
`define ITMR_OFS_CTRL 8'h00
`define ITMR_OFS_LOAD 8'h04
`define ITMR_OFS_COUNT 8'h08
`define ITMR_OFS_IRQ_STAT 8'h30
`define ITMR_OFS_IRQ_MASK 8'h34

// field positions
`define ITMR_CTRL_MODE_LSB 0
`define ITMR_CTRL_BCD_BIT 3
`define ITMR_CTRL_SWTRIG_BIT 4
`define ITMR_COUNT_OUT_BIT 16

// reset values
`define ITMR_RST_LOAD 16'h0000
`define ITMR_RST_MASK 2'h0

// bus answers
`define ITMR_RESP_OKAY 2'h0
`define ITMR_RESP_SLVERR 2'h2

`endif

// file: itmr_pkg.sv
// Purpose: shared types of the interval timer
// Assumes: nothing
// Notes: mode code 7 is illegal and leaves a channel idle
package itmr_pkg;
   typedef enum logic [2:0] {
      MD_TCINT,
      MD_ONESHOT,
      MD_RATE,
      MD_SQUARE,
      MD_SWSTB,
      MD_HWSTB,
      MD_EVENT
   } itmr_mode_t;
endpackage : itmr_pkg

// file: itmr_chan_if.sv
// Purpose: control and status between register file and one counter channel
// Assumes: both ends on mclk
// Notes: loadStb and swTrig are one-cycle pulses
`timescale 1ns/1ns
interface itmr_chan_if #(
   parameter int CNT_W = 16
);
   itmr_pkg::itmr_mode_t mode;
   logic bcd;
   logic [CNT_W-1:0] loadVal;
   logic loadStb;
   logic swTrig;
   logic tick;
   logic gate;
   logic [CNT_W-1:0] count;
   logic out;
   logic tc;
   modport ctl (output mode, bcd, loadVal, loadStb, swTrig, tick, gate,
                input count, out, tc);
   modport chan (input mode, bcd, loadVal, loadStb, swTrig, tick, gate,
                 output count, out, tc);
endinterface : itmr_chan_if

// file: itmr_channel.sv
// Purpose: one down-counting channel with seven counting functions
// Assumes: tick and gate already synchronous to mclk
// Notes: out idles high after reset
`timescale 1ns/1ns
module itmr_channel #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // control and status
   itmr_chan_if.chan bus
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic out;
      logic run;
      logic gatePrev;
      logic tc;
   } itmr_chan_state_t;

   itmr_chan_state_t state_r;
   itmr_chan_state_t state_nxt;
   logic [CNT_W-1:0] decVal;
   logic gateRise;
   logic runTick;
   logic cntTick;
   logic isSw;

   // binary or per-digit decimal decrement, wrapping from zero
   function automatic logic [CNT_W-1:0] decr(input logic [CNT_W-1:0] v, input logic dec);
      logic [CNT_W-1:0] r;
      logic borrow;
      r = v - {{(CNT_W-1){1'b0}}, 1'b1};
      borrow = 1'b1;
      if (dec) begin
         for (int i = 0; i < CNT_W / 4; i++) begin
            if (!borrow) begin
               r[4*i +: 4] = v[4*i +: 4];
            end else if (v[4*i +: 4] == 4'h0) begin
               r[4*i +: 4] = 4'h9;
            end else begin
               r[4*i +: 4] = v[4*i +: 4] - 4'h1;
               borrow = 1'b0;
            end
         end
      end
      return r;
   endfunction : decr

   always_comb begin
      state_nxt = state_r;
      state_nxt.tc = 1'b0;
      state_nxt.gatePrev = bus.gate;
      gateRise = bus.gate && !state_r.gatePrev;
      decVal = decr(state_r.cnt, bus.bcd);
      runTick = bus.tick && state_r.run;
      cntTick = runTick && bus.gate;
      isSw = (bus.mode == itmr_pkg::MD_SWSTB);
      unique case (bus.mode)
         itmr_pkg::MD_TCINT: begin
            if (bus.loadStb) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b0;
               state_nxt.run = 1'b1;
            end else if (cntTick) begin
               state_nxt.cnt = decVal;
               if (decVal == '0) begin
                  state_nxt.out = 1'b1;
                  state_nxt.tc = 1'b1;
                  state_nxt.run = 1'b0;
               end
            end
         end
         itmr_pkg::MD_ONESHOT: begin
            if (bus.loadStb) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b1;
               state_nxt.run = 1'b0;
            end else if (gateRise || bus.swTrig) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b0;
               state_nxt.run = 1'b1;
            end else if (runTick) begin
               state_nxt.cnt = decVal;
               if (decVal == '0) begin
                  state_nxt.out = 1'b1;
                  state_nxt.tc = 1'b1;
                  state_nxt.run = 1'b0;
               end
            end
         end
         itmr_pkg::MD_RATE, itmr_pkg::MD_SQUARE: begin
            if (bus.loadStb) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b1;
               state_nxt.run = 1'b1;
            end else if (cntTick) begin
               if (state_r.cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                  state_nxt.cnt = bus.loadVal;
                  state_nxt.tc = 1'b1;
                  state_nxt.out = (bus.mode == itmr_pkg::MD_SQUARE);
               end else begin
                  state_nxt.cnt = decVal;
                  // half point taken in binary, so decimal square waves are uneven
                  state_nxt.out = (bus.mode == itmr_pkg::MD_RATE) ||
                                  (decVal > (bus.loadVal >> 1));
               end
            end
         end
         itmr_pkg::MD_SWSTB, itmr_pkg::MD_HWSTB: begin
            if (bus.loadStb) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b1;
               state_nxt.run = isSw;
            end else if (!isSw && gateRise) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b1;
               state_nxt.run = 1'b1;
            end else begin
               if (bus.tick && !state_r.out) begin
                  state_nxt.out = 1'b1;
               end
               if (isSw ? cntTick : runTick) begin
                  state_nxt.cnt = decVal;
                  if (decVal == '0) begin
                     state_nxt.out = 1'b0;
                     state_nxt.tc = 1'b1;
                     state_nxt.run = 1'b0;
                  end
               end
            end
         end
         itmr_pkg::MD_EVENT: begin
            if (bus.loadStb) begin
               state_nxt.cnt = bus.loadVal;
               state_nxt.out = 1'b0;
               state_nxt.run = 1'b1;
            end else if (cntTick) begin
               state_nxt.cnt = decVal;
               if (decVal == '0) begin
                  state_nxt.out = 1'b1;
                  state_nxt.tc = 1'b1;
               end
            end
         end
         default: begin
            state_nxt.run = 1'b0;
         end
      endcase
      if (rst) begin
         state_nxt = '0;
         state_nxt.out = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      state_r <= state_nxt;
   end

   assign bus.count = state_r.cnt;
   assign bus.out = state_r.out;
   assign bus.tc = state_r.tc;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_oneshot_trig;
      bus.mode == itmr_pkg::MD_ONESHOT && !bus.loadStb && (gateRise || bus.swTrig)
         |=> !bus.out && bus.count == $past(bus.loadVal);
   endproperty
   a_oneshot_trig: assert property (p_oneshot_trig) else $error("one-shot not started");

   property p_hw_retrig;
      bus.mode == itmr_pkg::MD_HWSTB && !bus.loadStb && gateRise
         |=> bus.out && bus.count == $past(bus.loadVal);
   endproperty
   a_hw_retrig: assert property (p_hw_retrig) else $error("hardware strobe not restarted");
endmodule : itmr_channel

// file: itmr_top.sv
// Purpose: three-channel interval timer reached over AXI4-Lite
// Assumes: mclk 100 MHz, rst synchronous active high
// Notes: gate and event pins are asynchronous and pass two flops
`timescale 1ns/1ns
`include "itmr_cfg.svh"
module itmr_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // external timer lines
   input wire logic [1:0] gateIn,
   input wire logic [1:0] eventIn,
   output logic [1:0] timerOut,
   output logic baudClk,
   // interrupt
   output logic irq
);
   localparam int N_CH = 3;
   localparam int CNT_W = 16;

   typedef struct packed {
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      itmr_pkg::itmr_mode_t [N_CH-1:0] mode;
      logic [N_CH-1:0] bcd;
      logic [N_CH-1:0][CNT_W-1:0] loadVal;
      logic [N_CH-1:0] loadStb;
      logic [N_CH-1:0] swTrig;
      logic [1:0] gateQ1;
      logic [1:0] gateQ2;
      logic [1:0] evtQ1;
      logic [1:0] evtQ2;
      logic [1:0] evtQ3;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic irq;
   } itmr_top_state_t;

   itmr_top_state_t state_r;
   itmr_top_state_t state_nxt;
   logic [31:0] rdVal;
   logic [1:0] rdResp;
   logic [1:0] stClr;
   logic wrHit;
   logic [N_CH-1:0] chTc;
   logic [N_CH-1:0] chOut;
   logic [N_CH-1:0][CNT_W-1:0] chCount;

   itmr_chan_if #(.CNT_W(CNT_W)) chIf [N_CH] ();

   function automatic logic [7:0] chBase(input int c);
      return 8'(c) * `ITMR_CH_STRIDE;
   endfunction : chBase

   always_comb begin
      state_nxt = state_r;
      rdVal = '0;
      rdResp = `ITMR_RESP_SLVERR;
      stClr = '0;
      wrHit = 1'b0;
      state_nxt.loadStb = '0;
      state_nxt.swTrig = '0;
      // pins are asynchronous; only stage two onward is looked at
      state_nxt.gateQ1 = gateIn;
      state_nxt.gateQ2 = state_r.gateQ1;
      state_nxt.evtQ1 = eventIn;
      state_nxt.evtQ2 = state_r.evtQ1;
      state_nxt.evtQ3 = state_r.evtQ2;

      // write side: address and data may come in either order
      if (awvalid && state_r.awready) begin
         state_nxt.awHeld = 1'b1;
         state_nxt.awAddr = awaddr;
      end
      if (wvalid && state_r.wready) begin
         state_nxt.wHeld = 1'b1;
         state_nxt.wData = wdata;
         state_nxt.wStrb = wstrb;
      end
      if (state_r.bvalid && bready) begin
         state_nxt.bvalid = 1'b0;
      end
      if (state_r.awHeld && state_r.wHeld && !state_r.bvalid) begin
         for (int c = 0; c < N_CH; c++) begin
            if (state_r.awAddr == chBase(c) + `ITMR_OFS_CTRL) begin
               wrHit = 1'b1;
               if (state_r.wStrb[0]) begin
                  state_nxt.mode[c] = itmr_pkg::itmr_mode_t'(
                     state_r.wData[`ITMR_CTRL_MODE_LSB +: 3]);
                  state_nxt.bcd[c] = state_r.wData[`ITMR_CTRL_BCD_BIT];
                  state_nxt.swTrig[c] = state_r.wData[`ITMR_CTRL_SWTRIG_BIT];
               end
            end
            if (state_r.awAddr == chBase(c) + `ITMR_OFS_LOAD) begin
               wrHit = 1'b1;
               if (state_r.wStrb[0]) begin
                  state_nxt.loadVal[c][7:0] = state_r.wData[7:0];
               end
               if (state_r.wStrb[1]) begin
                  state_nxt.loadVal[c][15:8] = state_r.wData[15:8];
               end
               state_nxt.loadStb[c] = |state_r.wStrb[1:0];
            end
            if (state_r.awAddr == chBase(c) + `ITMR_OFS_COUNT) begin
               wrHit = 1'b1;
            end
         end
         if (state_r.awAddr == `ITMR_OFS_IRQ_STAT) begin
            wrHit = 1'b1;
            if (state_r.wStrb[0]) begin
               stClr = state_r.wData[1:0];
            end
         end
         if (state_r.awAddr == `ITMR_OFS_IRQ_MASK) begin
            wrHit = 1'b1;
            if (state_r.wStrb[0]) begin
               state_nxt.irqMask = state_r.wData[1:0];
            end
         end
         state_nxt.awHeld = 1'b0;
         state_nxt.wHeld = 1'b0;
         state_nxt.bvalid = 1'b1;
         state_nxt.bresp = wrHit ? `ITMR_RESP_OKAY : `ITMR_RESP_SLVERR;
      end
      state_nxt.awready = !state_nxt.awHeld && !state_nxt.bvalid;
      state_nxt.wready = !state_nxt.wHeld && !state_nxt.bvalid;

      // read side: live count is sampled, the channel never pauses
      for (int c = 0; c < N_CH; c++) begin
         if (araddr == chBase(c) + `ITMR_OFS_CTRL) begin
            rdVal[`ITMR_CTRL_MODE_LSB +: 3] = state_r.mode[c];
            rdVal[`ITMR_CTRL_BCD_BIT] = state_r.bcd[c];
            rdResp = `ITMR_RESP_OKAY;
         end
         if (araddr == chBase(c) + `ITMR_OFS_LOAD) begin
            rdVal[CNT_W-1:0] = state_r.loadVal[c];
            rdResp = `ITMR_RESP_OKAY;
         end
         if (araddr == chBase(c) + `ITMR_OFS_COUNT) begin
            rdVal[CNT_W-1:0] = chCount[c];
            rdVal[`ITMR_COUNT_OUT_BIT] = chOut[c];
            rdResp = `ITMR_RESP_OKAY;
         end
      end
      if (araddr == `ITMR_OFS_IRQ_STAT) begin
         rdVal[1:0] = state_r.irqStat;
         rdResp = `ITMR_RESP_OKAY;
      end
      if (araddr == `ITMR_OFS_IRQ_MASK) begin
         rdVal[1:0] = state_r.irqMask;
         rdResp = `ITMR_RESP_OKAY;
      end
      if (state_r.rvalid && rready) begin
         state_nxt.rvalid = 1'b0;
      end
      if (arvalid && state_r.arready) begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rdata = rdVal;
         state_nxt.rresp = rdResp;
      end
      state_nxt.arready = !state_nxt.rvalid;

      // terminal count of channels 0 and 1; a new event beats a clear
      state_nxt.irqStat = (state_r.irqStat & ~stClr) | chTc[1:0];
      state_nxt.irq = |(state_r.irqStat & state_r.irqMask);

      if (rst) begin
         state_nxt = '0;
         state_nxt.awready = 1'b1;
         state_nxt.wready = 1'b1;
         state_nxt.arready = 1'b1;
         state_nxt.irqMask = `ITMR_RST_MASK;
         for (int c = 0; c < N_CH; c++) begin
            state_nxt.mode[c] = itmr_pkg::MD_TCINT;
            state_nxt.loadVal[c] = `ITMR_RST_LOAD;
         end
      end
   end

   always_ff @(posedge mclk) begin
      state_r <= state_nxt;
   end

   for (genvar g = 0; g < N_CH; g++) begin : gCh
      assign chIf[g].mode = state_r.mode[g];
      assign chIf[g].bcd = state_r.bcd[g];
      assign chIf[g].loadVal = state_r.loadVal[g];
      assign chIf[g].loadStb = state_r.loadStb[g];
      assign chIf[g].swTrig = state_r.swTrig[g];
      if (g < 2) begin : gExt
         // event mode counts rising pin edges, others count every mclk
         assign chIf[g].tick = (state_r.mode[g] != itmr_pkg::MD_EVENT) ||
                               (state_r.evtQ2[g] && !state_r.evtQ3[g]);
         assign chIf[g].gate = state_r.gateQ2[g];
      end else begin : gInt
         // bit-rate channel has no pins and runs free
         assign chIf[g].tick = 1'b1;
         assign chIf[g].gate = 1'b1;
      end
      assign chTc[g] = chIf[g].tc;
      assign chOut[g] = chIf[g].out;
      assign chCount[g] = chIf[g].count;
      itmr_channel #(.CNT_W(CNT_W)) uChan (
         .mclk(mclk),
         .rst(rst),
         .bus(chIf[g])
      );
   end

   assign awready = state_r.awready;
   assign wready = state_r.wready;
   assign bvalid = state_r.bvalid;
   assign bresp = state_r.bresp;
   assign arready = state_r.arready;
   assign rvalid = state_r.rvalid;
   assign rdata = state_r.rdata;
   assign rresp = state_r.rresp;
   assign timerOut = chOut[1:0];
   assign baudClk = chOut[2];
   assign irq = state_r.irq;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_wr_commit;
      state_r.awHeld && state_r.wHeld && !state_r.bvalid;
   endsequence

   property p_wr_resp;
      s_wr_commit |=> bvalid ##0 !awready ##0 !wready;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

   property p_ctrl_mode;
      s_wr_commit ##0 state_r.awAddr == `ITMR_OFS_CTRL ##0 state_r.wStrb[0]
         |=> chIf[0].mode == $past(state_r.wData[2:0]);
   endproperty
   a_ctrl_mode: assert property (p_ctrl_mode) else $error("mode not taken");

   property p_load_pulse;
      s_wr_commit ##0 state_r.awAddr == `ITMR_OFS_LOAD + `ITMR_CH_STRIDE ##0 state_r.wStrb[0]
         |=> chIf[1].loadStb ##1 !chIf[1].loadStb;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load strobe wrong");

   property p_rd_count;
      arvalid && arready && araddr == `ITMR_OFS_COUNT
         |=> rvalid && rdata[15:0] == $past(chIf[0].count) && rresp == `ITMR_RESP_OKAY;
   endproperty
   a_rd_count: assert property (p_rd_count) else $error("count read wrong");

   property p_irq_level;
      (|(state_r.irqStat & state_r.irqMask)) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not raised");

   property p_tc_sticky;
      chIf[1].tc |=> state_r.irqStat[1];
   endproperty
   a_tc_sticky: assert property (p_tc_sticky) else $error("status not set");

   property p_tcint_done;
      chIf[0].mode == itmr_pkg::MD_TCINT && chIf[0].tc |-> chIf[0].out && chIf[0].count == '0;
   endproperty
   a_tcint_done: assert property (p_tcint_done) else $error("terminal count wrong");

   property p_rate_pulse;
      chIf[2].mode == itmr_pkg::MD_RATE && !chIf[2].out && chIf[2].gate && !chIf[2].loadStb
         && chIf[2].count != 16'h0001 |=> chIf[2].out;
   endproperty
   a_rate_pulse: assert property (p_rate_pulse) else $error("rate pulse too long");

   property p_square_tc;
      chIf[1].mode == itmr_pkg::MD_SQUARE && chIf[1].tc |-> chIf[1].out;
   endproperty
   a_square_tc: assert property (p_square_tc) else $error("square phase wrong");

   property p_swstb_load;
      chIf[0].mode == itmr_pkg::MD_SWSTB && chIf[0].loadStb
         |=> chIf[0].out && chIf[0].count == $past(chIf[0].loadVal);
   endproperty
   a_swstb_load: assert property (p_swstb_load) else $error("strobe load wrong");

   property p_event_hold;
      chIf[1].mode == itmr_pkg::MD_EVENT && !chIf[1].tick && !chIf[1].loadStb
         |=> $stable(chIf[1].count);
   endproperty
   a_event_hold: assert property (p_event_hold) else $error("count moved without event");

   property p_dec_one;
      chIf[0].mode == itmr_pkg::MD_TCINT && !chIf[0].out && chIf[0].gate && !chIf[0].bcd
         && !chIf[0].loadStb && chIf[0].count != '0
         |=> chIf[0].count == $past(chIf[0].count) - 16'h0001;
   endproperty
   a_dec_one: assert property (p_dec_one) else $error("decrement wrong");

   property p_bcd_digit;
      chIf[1].mode == itmr_pkg::MD_EVENT && chIf[1].bcd && chIf[1].tick && chIf[1].gate
         && !chIf[1].loadStb && chIf[1].count[3:0] == 4'h0 && chIf[1].count[7:4] != 4'h0
         && !chIf[1].out |=> chIf[1].count[3:0] == 4'h9;
   endproperty
   a_bcd_digit: assert property (p_bcd_digit) else $error("decimal borrow wrong");
endmodule : itmr_top

// file: itmr_ext_model.sv
// Purpose: far-side model of the gate and event pins
// Assumes: driven from the bench by task calls
// Notes: gates idle high so gated functions count
`timescale 1ns/1ns
module itmr_ext_model (
   // clock
   input wire logic mclk,
   // lines toward the timer
   output logic [1:0] gateIn,
   output logic [1:0] eventIn
);
   initial begin
      gateIn = 2'b11;
      eventIn = 2'b00;
   end
   task automatic set_gate(input int c, input logic v);
      @(posedge mclk);
      gateIn[c] <= v;
   endtask : set_gate
   // wide pulse, pins pass two flops on the far side
   task automatic pulse_event(input int c);
      @(posedge mclk);
      eventIn[c] <= 1'b1;
      repeat (4) @(posedge mclk);
      eventIn[c] <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : pulse_event
endmodule : itmr_ext_model

// file: itmr_bench.sv
// Purpose: register-level test of the interval timer
// Assumes: design answers within 50 cycles
// Notes: output low cycles are counted per channel
`timescale 1ns/1ns
module itmr_bench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   wire awready, wready, bvalid, arready, rvalid, baudClk, irq;
   wire [1:0] bresp, rresp, gateIn, eventIn, timerOut;
   wire [31:0] rdata;
   wire [2:0] outs = {baudClk, timerOut};
   int errors = 0, checks_done = 0, s = 0;
   int lc[3] = '{0, 0, 0};
   always #5 mclk = ~mclk;
   // counted on the falling edge, where outputs have settled
   always @(negedge mclk) for (int i = 0; i < 3; i++) if (outs[i] === 1'b0) lc[i]++;
   itmr_top itmr_top_inst (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .gateIn, .eventIn, .timerOut, .baudClk, .irq);
   itmr_ext_model itmr_ext_model_inst (.mclk, .gateIn, .eventIn);
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt
   // address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw, w;
      @(posedge mclk);
      n = 0; aw = 0; w = 0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awready === 1'b1 && !aw) begin aw = 1; awvalid <= 1'b0; end
         if (wready === 1'b1 && !w) begin w = 1; wvalid <= 1'b0; end
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      if (n >= 50) begin errors++; end_of_test(); end
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
         input logic [1:0] er);
      int n;
      @(posedge mclk);
      n = 0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      if (n >= 50) begin errors++; end_of_test(); end
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd
   initial begin
      wt(20);
      rst <= 1'b0;
      rd(8'h34, 32'h0, 32'h3, 2'h0);
      rd(8'h08, 32'h10000, 32'h1ffff, 2'h0);
      rd(8'h40, 32'h0, 32'h0, 2'h2);
      wr(8'h3c, 32'h1, 2'h2);
      wr(8'h00, 32'h0, 2'h0);
      wr(8'h04, 32'h5, 2'h0);
      wt(20);
      rd(8'h08, 32'h10000, 32'h1ffff, 2'h0);
      rd(8'h30, 32'h1, 32'h1, 2'h0);
      chk({31'h0, irq}, 32'h0);
      wr(8'h34, 32'h1, 2'h0);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      wr(8'h30, 32'h1, 2'h0);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      wr(8'h00, 32'h1, 2'h0);
      wr(8'h04, 32'h8, 2'h0);
      wr(8'h00, 32'h11, 2'h0);
      rd(8'h08, 32'h0, 32'h10000, 2'h0);
      wt(20);
      rd(8'h08, 32'h10000, 32'h10000, 2'h0);
      wr(8'h00, 32'h4, 2'h0);
      s = lc[0];
      wr(8'h04, 32'h3, 2'h0);
      wt(15);
      chk(lc[0] - s, 32'h1);
      itmr_ext_model_inst.set_gate(0, 1'b0);
      wr(8'h00, 32'h5, 2'h0);
      wr(8'h04, 32'h6, 2'h0);
      wt(10);
      s = lc[0];
      itmr_ext_model_inst.set_gate(0, 1'b1);
      wt(20);
      chk(lc[0] - s, 32'h1);
      wr(8'h10, 32'h3, 2'h0);
      wr(8'h14, 32'h8, 2'h0);
      wt(10);
      s = lc[1];
      wt(32);
      chk(lc[1] - s, 32'h10);
      // binary divide by 4, then decimal divide by ten
      for (int i = 0; i < 2; i++) begin
         wr(8'h20, i ? 32'ha : 32'h2, 2'h0);
         wr(8'h24, i ? 32'h10 : 32'h4, 2'h0);
         wt(20);
         s = lc[2];
         wt(i ? 100 : 40);
         chk(lc[2] - s, 32'ha);
      end
      // decimal event count across a digit borrow
      wr(8'h10, 32'he, 2'h0);
      wr(8'h14, 32'h31, 2'h0);
      rd(8'h10, 32'he, 32'h1f, 2'h0);
      rd(8'h14, 32'h31, 32'hffff, 2'h0);
      repeat (3) itmr_ext_model_inst.pulse_event(1);
      wt(10);
      rd(8'h18, 32'h28, 32'h1ffff, 2'h0);
      wr(8'h18, 32'h0, 2'h0);
      rd(8'h18, 32'h28, 32'h1ffff, 2'h0);
      end_of_test();
   end
endmodule : itmr_bench
